// *** verilog/pdem_regs.vh ***
// constants for the port d / port e alternate function mux
`ifndef PDEM_REGS_VH
`define PDEM_REGS_VH

// ****************************************************************
// widths and reset values
// ****************************************************************
`define PDEM_PORT_W        8
`define PDEM_RST_BYTE      8'h00
`define PDEM_ONES_BYTE     8'hff

// ****************************************************************
// pin positions
// ****************************************************************
`define PDEM_PD_CAPTURE    0
`define PDEM_PD_IRQ0       1
`define PDEM_PE_RXD        0
`define PDEM_PE_TXD        1
`define PDEM_PE_XCK        2
`define PDEM_PE_SERIAL_IFACE_CLOCK       4
`define PDEM_PE_SDI        5
`define PDEM_PE_SDO        6
`define PDEM_PE_CLKOUT     7

// ****************************************************************
// divided clock output: core cycles per half period
// ****************************************************************
`define PDEM_CLKOUT_HALF   8

`endif

// *** verilog/pdem_sync.v ***
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module pdem_sync #(
   parameter W = 8
) (
   // clock, reset, enable
   input  wire         core_clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // data
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // ****************************************************************
   // stage one is read by stage two only
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // pdem_sync

// *** verilog/pdem_clk_div.v ***
// free-running divider that makes the divided system clock
`timescale 1ns/100ps
`include "pdem_regs.vh"
module pdem_clk_div #(
   parameter HALF = `PDEM_CLKOUT_HALF
) (
   // clock, enable
   input  wire core_clk_i,
   input  wire ce_i,
   // control
   input  wire run_i,
   // divided clock
   output wire div_clk_o
);

   localparam integer LAST_I = HALF - 1;
   localparam [15:0]  LAST   = LAST_I[15:0];

   reg [15:0] cnt_q;
   reg        div_q;

   // ****************************************************************
   // system reset is deliberately ignored so the clock keeps running
   // through reset; the fuse level alone parks the divider
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (ce_i) begin
         if (!run_i) begin
            cnt_q <= 16'h0000;
            div_q <= 1'b0;
         end else if (cnt_q >= LAST) begin
            cnt_q <= 16'h0000;
            div_q <= ~div_q;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   assign div_clk_o = div_q;

endmodule // pdem_clk_div

// *** verilog/pdem_mux.v ***
// port d / port e alternate function override logic
// Notes on behaviour
// - port d bit 0 digital input drives the timer one capture input.
// - port d pull-up override enable is lcd enable and mask bit, value 0.
// - port d direction override enable is lcd enable and mask, value input.
// - port d input enable override on all bits but 1 is lcd and mask, 0.
// - port d bit 1 input enable override is lcd or irq0 enable, value and.
// - with the clock fuse set, port e bit 7 drives the divided clock.
// - the divided clock stays on port e bit 7 during system reset.
// - every port e pin is the pin change source of its own bit number.
// - in sync mode port e bit 2 direction picks sync clock out or in.
// - the sync clock function on port e bit 2 is dead outside sync mode.
// - serial data out on e6, data in on e5, serial clock on e4.
// - usart transmit drives port e bit 1, receive reads port e bit 0.
// - with receiver on, e0 is an input and its port value sets pull-up.
`timescale 1ns/100ps
`include "pdem_regs.vh"
module pdem_mux #(
   parameter W        = `PDEM_PORT_W,
   parameter CLK_HALF = `PDEM_CLKOUT_HALF
) (
   // clock, reset, enable
   input  wire         core_clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // port d normal port settings
   input  wire [W-1:0] pd_value_i,
   input  wire [W-1:0] pd_direction_i,
   input  wire [W-1:0] pd_input_enable_i,
   input  wire [W-1:0] pd_pin_i,
   // lcd and interrupt controls
   input  wire         lcd_drive_enable_i,
   input  wire [W-1:0] lcd_pin_mask_i,
   input  wire [W-1:0] segment_drive_line_i,
   input  wire         irq_zero_enable_i,
   // port e normal port settings
   input  wire [W-1:0] pe_value_i,
   input  wire [W-1:0] pe_direction_i,
   input  wire [W-1:0] pe_pin_i,
   // port e function controls
   input  wire         clock_output_fuse_i,
   input  wire         usart_sync_mode_i,
   input  wire         usart_sync_clock_i,
   input  wire         usart_tx_enable_i,
   input  wire         usart_tx_data_i,
   input  wire         usart_rx_enable_i,
   input  wire         serial_iface_three_wire_i,
   input  wire         serial_iface_data_out_i,
   // port d override signals
   output reg  [W-1:0] pullup_override_enable_o,
   output reg  [W-1:0] pullup_override_value_o,
   output reg  [W-1:0] direction_override_enable_o,
   output reg  [W-1:0] direction_override_value_o,
   output reg  [W-1:0] output_value_override_enable_o,
   output reg  [W-1:0] output_value_override_value_o,
   output reg  [W-1:0] input_enable_override_enable_o,
   output reg  [W-1:0] input_enable_override_value_o,
   output reg  [W-1:0] analog_path_o,
   // port d resolved pad controls
   output reg  [W-1:0] pd_pullup_o,
   output reg  [W-1:0] pd_direction_o,
   output reg  [W-1:0] pd_out_o,
   output reg  [W-1:0] pd_input_enable_o,
   // port d alternate inputs
   output reg          timer_one_capture_in_o,
   output reg          external_irq_zero_o,
   // port e resolved pad controls
   output reg  [W-1:0] pe_pullup_o,
   output reg  [W-1:0] pe_direction_o,
   output reg  [W-1:0] pe_out_o,
   // port e alternate inputs
   output reg  [W-1:0] pin_change_source_o,
   output reg          usart_sync_clock_o,
   output reg          usart_rx_data_o,
   output reg          serial_iface_data_in_o,
   output reg          serial_iface_clock_o
);

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   wire [W-1:0] pd_sync;
   wire [W-1:0] pe_sync;
   wire         div_clk;

   pdem_sync #(
      .W (W)
   ) u_pd_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .async_i    (pd_pin_i),
      .sync_o     (pd_sync)
   );

   pdem_sync #(
      .W (W)
   ) u_pe_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .async_i    (pe_pin_i),
      .sync_o     (pe_sync)
   );

   // ****************************************************************
   // divided clock source
   // ****************************************************************
   pdem_clk_div #(
      .HALF (CLK_HALF)
   ) u_clk_div (
      .core_clk_i (core_clk_i),
      .ce_i       (ce_i),
      .run_i      (clock_output_fuse_i),
      .div_clk_o  (div_clk)
   );

   // ****************************************************************
   // port d per-pin override terms
   // ****************************************************************
   wire [W-1:0] pd_lcd_take;
   wire [W-1:0] pd_pu_oe_d;
   wire [W-1:0] pd_dd_oe_d;
   wire [W-1:0] pd_ie_oe_d;
   wire [W-1:0] pd_ie_ov_d;
   wire [W-1:0] pd_pullup_d;
   wire [W-1:0] pd_dir_d;
   wire [W-1:0] pd_out_d;
   wire [W-1:0] pd_ie_d;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pd
         assign pd_lcd_take[i] = lcd_drive_enable_i & lcd_pin_mask_i[i];
         assign pd_pu_oe_d[i]  = pd_lcd_take[i];
         assign pd_dd_oe_d[i]  = pd_lcd_take[i];
         if (i == `PDEM_PD_IRQ0) begin : g_irq
            // lcd enable alone, not masked, shares the pin with irq0
            assign pd_ie_oe_d[i] = lcd_drive_enable_i |
                                   irq_zero_enable_i;
            assign pd_ie_ov_d[i] = lcd_drive_enable_i &
                                   irq_zero_enable_i;
         end else begin : g_seg
            assign pd_ie_oe_d[i] = pd_lcd_take[i];
            assign pd_ie_ov_d[i] = 1'b0;
         end
         // override values are 0 for pull-up, direction and output
         assign pd_pullup_d[i] = pd_pu_oe_d[i] ? 1'b0 :
                                 pd_value_i[i] & ~pd_direction_i[i];
         assign pd_dir_d[i]    = pd_dd_oe_d[i] ? 1'b0 :
                                 pd_direction_i[i];
         assign pd_out_d[i]    = pd_value_i[i];
         assign pd_ie_d[i]     = pd_ie_oe_d[i] ? pd_ie_ov_d[i] :
                                 pd_input_enable_i[i];
      end
   endgenerate

   // ****************************************************************
   // port d registers
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         pullup_override_enable_o       <= `PDEM_RST_BYTE;
         pullup_override_value_o        <= `PDEM_RST_BYTE;
         direction_override_enable_o    <= `PDEM_RST_BYTE;
         direction_override_value_o     <= `PDEM_RST_BYTE;
         output_value_override_enable_o <= `PDEM_RST_BYTE;
         output_value_override_value_o  <= `PDEM_RST_BYTE;
         input_enable_override_enable_o <= `PDEM_RST_BYTE;
         input_enable_override_value_o  <= `PDEM_RST_BYTE;
         analog_path_o                  <= `PDEM_RST_BYTE;
         pd_pullup_o                    <= `PDEM_RST_BYTE;
         pd_direction_o                 <= `PDEM_RST_BYTE;
         pd_out_o                       <= `PDEM_RST_BYTE;
         pd_input_enable_o              <= `PDEM_RST_BYTE;
         timer_one_capture_in_o         <= 1'b0;
         external_irq_zero_o            <= 1'b0;
      end else if (ce_i) begin
         pullup_override_enable_o       <= pd_pu_oe_d;
         pullup_override_value_o        <= `PDEM_RST_BYTE;
         direction_override_enable_o    <= pd_dd_oe_d;
         direction_override_value_o     <= `PDEM_RST_BYTE;
         output_value_override_enable_o <= `PDEM_RST_BYTE;
         output_value_override_value_o  <= `PDEM_RST_BYTE;
         input_enable_override_enable_o <= pd_ie_oe_d;
         input_enable_override_value_o  <= pd_ie_ov_d;
         analog_path_o                  <= segment_drive_line_i;
         pd_pullup_o                    <= pd_pullup_d;
         pd_direction_o                 <= pd_dir_d;
         pd_out_o                       <= pd_out_d;
         pd_input_enable_o              <= pd_ie_d;
         timer_one_capture_in_o         <= pd_sync[`PDEM_PD_CAPTURE];
         external_irq_zero_o            <= pd_sync[`PDEM_PD_IRQ0];
      end
   end

   // ****************************************************************
   // port e function takes
   // ****************************************************************
   // only the three-wire data out is carried; two-wire overrides are not
   wire pe_xck_out_take;
   wire pe_xck_in_take;
   wire pe_sdo_take;
   wire pe_tx_take;
   wire pe_rx_take;
   wire pe_clk_take;

   // the sync clock pin belongs to the usart in sync mode only
   assign pe_xck_out_take = usart_sync_mode_i &
                            pe_direction_i[`PDEM_PE_XCK];
   assign pe_xck_in_take  = usart_sync_mode_i &
                            ~pe_direction_i[`PDEM_PE_XCK];
   assign pe_sdo_take     = serial_iface_three_wire_i;
   assign pe_tx_take      = usart_tx_enable_i;
   assign pe_rx_take      = usart_rx_enable_i;
   // a static fuse level, so it is read without a synchroniser
   assign pe_clk_take     = clock_output_fuse_i;

   // ****************************************************************
   // port e resolution
   // ****************************************************************
   reg [W-1:0] pe_pullup_d;
   reg [W-1:0] pe_dir_d;
   reg [W-1:0] pe_out_d;

   always @* begin
      // normal port behaviour first, functions override below
      pe_pullup_d = pe_value_i & ~pe_direction_i;
      pe_dir_d    = pe_direction_i;
      pe_out_d    = pe_value_i;
      // sync clock out mirrors onto the pull-up as well
      if (pe_xck_out_take) begin
         pe_out_d[`PDEM_PE_XCK]    = usart_sync_clock_i;
         pe_pullup_d[`PDEM_PE_XCK] = usart_sync_clock_i;
      end
      // three-wire mode hands the data out pin to the serial interface
      if (pe_sdo_take) begin
         pe_out_d[`PDEM_PE_SDO] = serial_iface_data_out_i;
      end
      // the transmitter owns direction, value and pull-up of its pin
      if (pe_tx_take) begin
         pe_pullup_d[`PDEM_PE_TXD] = 1'b0;
         pe_dir_d[`PDEM_PE_TXD]    = 1'b1;
         pe_out_d[`PDEM_PE_TXD]    = usart_tx_data_i;
      end
      // the receiver forces its pin in; the port value picks the pull-up
      if (pe_rx_take) begin
         pe_dir_d[`PDEM_PE_RXD]    = 1'b0;
         pe_pullup_d[`PDEM_PE_RXD] = pe_value_i[`PDEM_PE_RXD];
      end
   end

   // ****************************************************************
   // port e registers
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (ce_i) begin
         if (rst_i) begin
            pe_pullup_o            <= `PDEM_RST_BYTE;
            pe_direction_o         <= `PDEM_RST_BYTE;
            pe_out_o               <= `PDEM_RST_BYTE;
            pin_change_source_o    <= `PDEM_RST_BYTE;
            usart_sync_clock_o     <= 1'b0;
            usart_rx_data_o        <= 1'b0;
            serial_iface_data_in_o <= 1'b0;
            serial_iface_clock_o   <= 1'b0;
         end else begin
            pe_pullup_o            <= pe_pullup_d;
            pe_direction_o         <= pe_dir_d;
            pe_out_o               <= pe_out_d;
            pin_change_source_o    <= pe_sync;
            // input side only in sync mode with the pin set as input
            usart_sync_clock_o     <= pe_xck_in_take &
                                      pe_sync[`PDEM_PE_XCK];
            usart_rx_data_o        <= pe_sync[`PDEM_PE_RXD];
            serial_iface_data_in_o <= pe_sync[`PDEM_PE_SDI];
            serial_iface_clock_o   <= pe_sync[`PDEM_PE_SERIAL_IFACE_CLOCK];
         end
         // placed last so it wins over reset and the port bits
         if (pe_clk_take) begin
            pe_out_o[`PDEM_PE_CLKOUT]       <= div_clk;
            pe_direction_o[`PDEM_PE_CLKOUT] <= 1'b1;
            pe_pullup_o[`PDEM_PE_CLKOUT]    <= 1'b0;
         end
      end else if (rst_i && !pe_clk_take) begin
         // reset still lands while frozen, unless the clock fuse is set
         pe_pullup_o            <= `PDEM_RST_BYTE;
         pe_direction_o         <= `PDEM_RST_BYTE;
         pe_out_o               <= `PDEM_RST_BYTE;
         pin_change_source_o    <= `PDEM_RST_BYTE;
         usart_sync_clock_o     <= 1'b0;
         usart_rx_data_o        <= 1'b0;
         serial_iface_data_in_o <= 1'b0;
         serial_iface_clock_o   <= 1'b0;
      end
   end

endmodule // pdem_mux

// *** sim/pdem_pads.sv ***
// pad model standing outside both ports: pin levels seen by the mux
`timescale 1ns/100ps
module pdem_pads (
   // clock for the floating pattern
   input  wire       core_clk_i,
   // resolved pad controls from the mux
   input  wire [7:0] dir_i,
   input  wire [7:0] out_i,
   input  wire [7:0] pull_i,
   // outside drivers
   input  wire [7:0] ext_i,
   input  wire [7:0] ext_en_i,
   // pad levels
   output wire [7:0] pin_o
);
   logic [7:0] float_q = 8'h00;

   // an undriven pad without pull-up wanders so no stale level survives
   always @(posedge core_clk_i) float_q <= ~float_q;

   assign pin_o = (dir_i & out_i) | (~dir_i & ext_en_i & ext_i) |
                  (~dir_i & ~ext_en_i & (pull_i | float_q));
endmodule // pdem_pads

// *** sim/pdem_mux_checker.sv ***
// concurrent checks on the ports of the alternate function mux
`timescale 1ns/100ps
module pdem_mux_checker #(
   parameter W = 8
) (
   // clock, reset, enable
   input wire         core_clk_i,
   input wire         rst_i,
   input wire         ce_i,
   // controls
   input wire         lcd_drive_enable_i,
   input wire [W-1:0] lcd_pin_mask_i,
   input wire [W-1:0] segment_drive_line_i,
   input wire         irq_zero_enable_i,
   input wire         clock_output_fuse_i,
   input wire         usart_rx_enable_i,
   input wire [W-1:0] pe_pin_i,
   // observed outputs
   input wire [W-1:0] pullup_override_enable_o,
   input wire [W-1:0] direction_override_enable_o,
   input wire [W-1:0] direction_override_value_o,
   input wire [W-1:0] input_enable_override_enable_o,
   input wire [W-1:0] analog_path_o,
   input wire [W-1:0] pe_direction_o,
   input wire [W-1:0] pin_change_source_o
);
   // ****************************************************************
   // override relations, one clock domain
   // ****************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_pullup_override: assert property (ce_i |=>
      pullup_override_enable_o ==
      ($past(lcd_pin_mask_i) & {W{$past(lcd_drive_enable_i)}}))
      else $error("pull-up override enable wrong");
   a_dir_override: assert property (ce_i |=>
      direction_override_value_o == 8'h00 &&
      direction_override_enable_o == ($past(lcd_pin_mask_i) &
      {W{$past(lcd_drive_enable_i)}})) else $error("direction override wrong");
   a_analog_path: assert property (ce_i |=>
      analog_path_o == $past(segment_drive_line_i))
      else $error("analog path wrong");
   a_ie_other_bits: assert property (ce_i |=>
      (input_enable_override_enable_o & 8'hfd) == ($past(lcd_pin_mask_i) &
      {W{$past(lcd_drive_enable_i)}} & 8'hfd)) else $error("input override");
   a_ie_irq_zero: assert property (ce_i |=>
      input_enable_override_enable_o[1] ==
      $past(lcd_drive_enable_i | irq_zero_enable_i))
      else $error("irq zero input override wrong");
   // synchroniser plus output register gives three edges of delay
   a_pin_change_src: assert property (ce_i [*3] |=>
      pin_change_source_o == $past(pe_pin_i, 3))
      else $error("pin change source lags wrongly");
   // kept through reset on purpose: the clock pin must not drop out
   a_clock_out_dir: assert property (disable iff (1'b0)
      ce_i && clock_output_fuse_i |=> pe_direction_o[7])
      else $error("clock pin not an output");
   a_rx_forced_in: assert property (ce_i && usart_rx_enable_i |=>
      !pe_direction_o[0]) else $error("receive pin not an input");
endmodule // pdem_mux_checker

bind pdem_mux pdem_mux_checker #(.W(W)) pdem_mux_checker_i (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .lcd_drive_enable_i(lcd_drive_enable_i), .lcd_pin_mask_i(lcd_pin_mask_i),
   .segment_drive_line_i(segment_drive_line_i),
   .irq_zero_enable_i(irq_zero_enable_i),
   .clock_output_fuse_i(clock_output_fuse_i),
   .usart_rx_enable_i(usart_rx_enable_i), .pe_pin_i(pe_pin_i),
   .pullup_override_enable_o(pullup_override_enable_o),
   .direction_override_enable_o(direction_override_enable_o),
   .direction_override_value_o(direction_override_value_o),
   .input_enable_override_enable_o(input_enable_override_enable_o),
   .analog_path_o(analog_path_o), .pe_direction_o(pe_direction_o),
   .pin_change_source_o(pin_change_source_o));

// *** sim/pdem_mux_tb.sv ***
// self-checking bench for the port d / port e alternate function mux
`timescale 1ns/100ps
module pdem_mux_tb;
   localparam CLK_HALF = 2;
   logic       core_clk_i = 1'b0;
   logic       rst_i      = 1'b1;
   logic       ce_i       = 1'b1;
   logic [7:0] pd_value_i, pd_direction_i, pd_input_enable_i, pd_pin_i;
   logic [7:0] lcd_pin_mask_i, segment_drive_line_i, pe_pin_i;
   logic [7:0] pe_value_i, pe_direction_i, pd_ext, pe_ext, pe_ext_en;
   logic       lcd_drive_enable_i, irq_zero_enable_i, clock_output_fuse_i;
   logic       usart_sync_mode_i, usart_sync_clock_i, usart_tx_enable_i;
   logic       usart_tx_data_i, usart_rx_enable_i;
   logic       serial_iface_three_wire_i, serial_iface_data_out_i;
   logic [7:0] pullup_override_enable_o, pullup_override_value_o;
   logic [7:0] direction_override_enable_o, direction_override_value_o;
   logic [7:0] output_value_override_enable_o, output_value_override_value_o;
   logic [7:0] input_enable_override_enable_o, input_enable_override_value_o;
   logic [7:0] analog_path_o, pd_pullup_o, pd_direction_o, pd_out_o;
   logic [7:0] pd_input_enable_o, pe_pullup_o, pe_direction_o, pe_out_o;
   logic [7:0] pin_change_source_o;
   logic       timer_one_capture_in_o, external_irq_zero_o;
   logic       usart_sync_clock_o, usart_rx_data_o;
   logic       serial_iface_data_in_o, serial_iface_clock_o;
   int         errors = 0;
   int         tests_run = 0;
   int         n;

   always #2 core_clk_i = ~core_clk_i;

   pdem_mux #(.W(8), .CLK_HALF(CLK_HALF)) pdem_mux_i (.*);
   pdem_pads pdem_pads_i (.core_clk_i(core_clk_i), .dir_i(pe_direction_o),
      .out_i(pe_out_o), .pull_i(pe_pullup_o), .ext_i(pe_ext),
      .ext_en_i(pe_ext_en), .pin_o(pe_pin_i));
   pdem_pads pdem_pads_d_i (.core_clk_i(core_clk_i), .dir_i(pd_direction_o),
      .out_i(pd_out_o), .pull_i(pd_pullup_o), .ext_i(pd_ext),
      .ext_en_i(8'hff), .pin_o(pd_pin_i));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task step(input int k);
      repeat (k) @(negedge core_clk_i);
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task summarize;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // rising edges of the clock pin over sixteen cycles
   task count_rises(output int c);
      logic p;
      c = 0;
      p = pe_out_o[7];
      repeat (16) begin
         step(1);
         if (!p && pe_out_o[7]) c++;
         p = pe_out_o[7];
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task t_lcd;
      pd_direction_i = 8'hff;
      pd_input_enable_i = 8'h3c;
      pd_value_i = 8'h0f;
      lcd_drive_enable_i = 1'b1;
      lcd_pin_mask_i = 8'ha5;
      segment_drive_line_i = 8'h96;
      step(1);
      chk(pullup_override_enable_o, 8'ha5);
      chk({pullup_override_value_o, pd_pullup_o}, 16'h0000);
      chk(direction_override_enable_o, 8'ha5);
      chk(pd_direction_o, 8'h5a);
      chk({output_value_override_enable_o,
           output_value_override_value_o}, 16'h0000);
      chk(pd_out_o, 8'h0f);
      chk(analog_path_o, 8'h96);
      chk(input_enable_override_enable_o, 8'ha7);
      chk(pd_input_enable_o, 8'h18);
      irq_zero_enable_i = 1'b1;
      step(1);
      chk(input_enable_override_value_o, 8'h02);
      lcd_drive_enable_i = 1'b0;
      step(1);
      chk(input_enable_override_enable_o, 8'h02);
      chk(input_enable_override_value_o, 8'h00);
      chk({pd_direction_o, pullup_override_enable_o}, 16'hff00);
      chk(pd_input_enable_o, 8'h3c);
      irq_zero_enable_i = 1'b0;
      pd_direction_i = 8'h00;
   endtask

   task t_pins;
      for (int i = 0; i < 2; i++) begin
         pe_ext = i ? 8'hca : 8'h35;
         pd_ext = i ? 8'h00 : 8'h03;
         step(3);
         chk(pin_change_source_o, pe_ext);
         chk({timer_one_capture_in_o, external_irq_zero_o},
             pd_ext[1:0]);
         chk({usart_rx_data_o, serial_iface_data_in_o,
              serial_iface_clock_o}, {pe_ext[0], pe_ext[5], pe_ext[4]});
         chk(usart_sync_clock_o, 1'b0);
      end
   endtask

   task t_usart;
      usart_sync_mode_i = 1'b1;
      usart_sync_clock_i = 1'b1;
      pe_direction_i = 8'h04;
      usart_tx_enable_i = 1'b1;
      usart_tx_data_i = 1'b1;
      serial_iface_three_wire_i = 1'b1;
      serial_iface_data_out_i = 1'b1;
      step(1);
      chk({pe_out_o[2], pe_direction_o[1], pe_out_o[1],
           pe_out_o[6]}, 4'hf);
      usart_sync_clock_i = 1'b0;
      usart_tx_data_i = 1'b0;
      serial_iface_data_out_i = 1'b0;
      step(1);
      chk({pe_out_o[2], pe_out_o[1], pe_out_o[6]}, 3'b000);
      // receive pin left floating so only the pull-up can lift it
      pe_direction_i = 8'h01;
      pe_ext = 8'h04;
      pe_ext_en = 8'hfe;
      pe_value_i = 8'h01;
      usart_rx_enable_i = 1'b1;
      // one edge for the pads to settle, then three through the sync path
      step(4);
      chk(usart_sync_clock_o, 1'b1);
      chk({pe_direction_o[0], pe_pullup_o[0], usart_rx_data_o}, 3'b011);
      usart_sync_mode_i = 1'b0;
      step(1);
      chk(usart_sync_clock_o, 1'b0);
      {usart_tx_enable_i, usart_rx_enable_i, serial_iface_three_wire_i} = 0;
      {pe_value_i, pe_direction_i, pe_ext_en} = {8'h00, 8'h00, 8'hff};
   endtask

   task t_clkout;
      clock_output_fuse_i = 1'b1;
      step(4);
      chk(pe_direction_o[7], 1'b1);
      count_rises(n);
      chk(n, 4);
      rst_i = 1'b1;
      count_rises(n);
      chk(n, 4);
      chk(pe_direction_o[7], 1'b1);
      rst_i = 1'b0;
      clock_output_fuse_i = 1'b0;
      step(2);
      chk(pe_direction_o[7], 1'b0);
   endtask

   // clock enable low must hold the pull-up override enable where it stands
   task t_freeze;
      ce_i = 1'b0;
      lcd_drive_enable_i = 1'b1;
      lcd_pin_mask_i = 8'hff;
      step(2);
      chk(pullup_override_enable_o, 8'h00);
      ce_i = 1'b1;
      step(1);
      chk(pullup_override_enable_o, 8'hff);
      lcd_drive_enable_i = 1'b0;
   endtask

   initial begin
      {pd_value_i, pd_direction_i, pd_input_enable_i, pd_ext, pe_ext} = 0;
      {lcd_pin_mask_i, segment_drive_line_i, pe_value_i, pe_direction_i} = 0;
      {lcd_drive_enable_i, irq_zero_enable_i, clock_output_fuse_i} = 0;
      {usart_sync_mode_i, usart_sync_clock_i, usart_tx_enable_i} = 0;
      {usart_tx_data_i, usart_rx_enable_i, serial_iface_three_wire_i} = 0;
      serial_iface_data_out_i = 1'b0;
      pe_ext_en = 8'hff;
      step(2);
      rst_i = 1'b0;
      t_lcd;
      $display("lcd override test done");
      t_pins;
      $display("pin input test done");
      t_usart;
      $display("usart and serial test done");
      t_clkout;
      $display("clock output test done");
      t_freeze;
      $display("clock enable test done");
      summarize;
   end

   // the whole run needs about sixty cycles
   initial begin
      repeat (1000) @(posedge core_clk_i);
      errors++;
      summarize;
   end
endmodule // pdem_mux_tb
